// *** design/multilayer_bus_matrix.sv ***
/*
 Multilayer bus matrix: five masters, seven slave ports, one arbiter
 per slave. Assumes masters hold a request stable until ready and
 slaves answer with ready (one cycle pulse) per accepted transfer.
*/
// Operation
// R1: Each slave has own arbiter, so disjoint pairs transfer in parallel.
// R2: Five master ports: instruction, data, system, two DMA.
// R3: Path table fixes which slaves each master reaches.
// R4: Pairs outside the table are answered with an error, never routed.
// R5: Code region fetches by instruction master go to flash instruction port.
// R6: Data master serves loads, stores and debug in the code region.
// R7: System master serves SRAM and peripheral regions.
// R8: Flash has separate instruction and data slave ports.
// R9: Matrix plus one AHB port and two peripheral bus ports.
// R10: Low speed peripheral bus clock at most 54 MHz.
// R11: High speed peripheral bus runs at system speed, up to 108 MHz.
// R12: Same-slave contention grants one, stalls others until completion.
`timescale 1ns/1ns
module multilayer_bus_matrix #(
   parameter int NM = bus_matrix_pkg::NUM_MASTERS, // R2
   parameter int NS = bus_matrix_pkg::NUM_SLAVES
) (
   input wire logic clock,
   input wire logic rst,
   input wire bus_matrix_pkg::req_s m_req [NM],
   output bus_matrix_pkg::rsp_s m_rsp [NM],
   output bus_matrix_pkg::req_s s_req [NS],
   input wire bus_matrix_pkg::rsp_s s_rsp [NS],
   output logic lo_periph_clk_en,
   output logic hi_periph_clk_en
);
   logic [NS-1:0] sel [NM];
   logic [NM-1:0] want [NS];
   logic [NM-1:0] grant_ff [NS];
   logic [NM-1:0] nxt_grant [NS];
   logic [NM-1:0] last_ff [NS];
   logic [NM-1:0] skip_mask [NS];
   logic [NM-1:0] err_ff;
   logic [NS-1:0] conn [NM];

   assign conn[bus_matrix_pkg::M_INSTR] = bus_matrix_pkg::CONN_INSTR; // R3
   assign conn[bus_matrix_pkg::M_DATA] = bus_matrix_pkg::CONN_DATA; // R3
   assign conn[bus_matrix_pkg::M_SYS] = bus_matrix_pkg::CONN_SYS; // R3
   assign conn[bus_matrix_pkg::M_DMA_A] = bus_matrix_pkg::CONN_DMA; // R3
   assign conn[bus_matrix_pkg::M_DMA_B] = bus_matrix_pkg::CONN_DMA; // R3

   function automatic logic in_rng(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   // Region decode; the flash port picks instruction or data by master
   function automatic logic [6:0] decode(input logic [31:0] a,
                                         input int m);
      logic [6:0] d;
      d = 7'h00;
      if (in_rng(a, bus_matrix_pkg::CODE_LO, bus_matrix_pkg::CODE_HI)) begin
         if (m == bus_matrix_pkg::M_INSTR)
            d[bus_matrix_pkg::S_FLASH_I] = 1'b1; // R8
         else
            d[bus_matrix_pkg::S_FLASH_D] = 1'b1; // R8
      end else if (in_rng(a, bus_matrix_pkg::SRAM_LO,
                          bus_matrix_pkg::SRAM_HI)) begin
         d[bus_matrix_pkg::S_SRAM] = 1'b1;
      end else if (in_rng(a, bus_matrix_pkg::APB_LO_LO,
                          bus_matrix_pkg::APB_LO_HI)) begin
         d[bus_matrix_pkg::S_APB_LO] = 1'b1; // R9
      end else if (in_rng(a, bus_matrix_pkg::APB_HI_LO,
                          bus_matrix_pkg::APB_HI_HI)) begin
         d[bus_matrix_pkg::S_APB_HI] = 1'b1; // R9
      end else if (in_rng(a, bus_matrix_pkg::AHB_LO,
                          bus_matrix_pkg::AHB_HI)) begin
         d[bus_matrix_pkg::S_AHB] = 1'b1; // R9
      end else if (in_rng(a, bus_matrix_pkg::EXT_LO,
                          bus_matrix_pkg::EXT_HI)) begin
         d[bus_matrix_pkg::S_EXTMEM] = 1'b1;
      end
      decode = d;
   endfunction

   // Decode masked by the path table; a miss becomes an error answer
   generate
      for (genvar m = 0; m < NM; m++) begin : g_dec
         assign sel[m] = m_req[m].valid ?
            (decode(m_req[m].addr, m) & conn[m]) : 7'h00; // R4 R5 R6 R7
      end
      for (genvar s = 0; s < NS; s++) begin : g_want
         for (genvar m = 0; m < NM; m++) begin : g_bit
            assign want[s][m] = sel[m][s];
         end
      end
   endgenerate

   // Highest index first past the last-served mask, one arbiter per slave: independent paths
   always_comb begin
      for (int s = 0; s < NS; s++) begin
         nxt_grant[s] = grant_ff[s];
         // A finishing master steps aside while anyone else waits
         skip_mask[s] = last_ff[s];
         if (s_rsp[s].ready && s_req[s].valid) begin
            skip_mask[s] = grant_ff[s];
         end
         if (grant_ff[s] == '0 ||
             (s_rsp[s].ready && s_req[s].valid) ||
             (want[s] & grant_ff[s]) == '0) begin // R12
            nxt_grant[s] = '0;
            for (int k = 2 * NM - 1; k >= 0; k--) begin
               if (k < NM && want[s][k] && !skip_mask[s][k] &&
                   nxt_grant[s] == '0) begin
                  nxt_grant[s][k] = 1'b1;
               end
            end
            if (nxt_grant[s] == '0) begin
               for (int k = NM - 1; k >= 0; k--) begin
                  if (want[s][k]) begin
                     nxt_grant[s] = '0;
                     nxt_grant[s][k] = 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < NS; s++) begin
            grant_ff[s] <= '0;
         end
      end else begin
         for (int s = 0; s < NS; s++) begin
            grant_ff[s] <= nxt_grant[s]; // R12
         end
      end
   end

   // Last-served mask keeps the winner from taking the next grant while another master waits
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < NS; s++) begin
            last_ff[s] <= '0;
         end
      end else begin
         for (int s = 0; s < NS; s++) begin
            if (s_rsp[s].ready && s_req[s].valid) begin
               last_ff[s] <= grant_ff[s];
            end
         end
      end
   end

   // Slave side muxes: each slave sees only its granted master
   always_comb begin
      for (int s = 0; s < NS; s++) begin
         s_req[s] = '0;
         for (int m = 0; m < NM; m++) begin
            if (grant_ff[s][m] && sel[m][s]) begin
               s_req[s] = m_req[m]; // R1
            end
         end
      end
   end

   // Unreachable pairs get a one-cycle error answer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         err_ff <= '0;
      end else begin
         for (int m = 0; m < NM; m++) begin
            err_ff[m] <= m_req[m].valid && sel[m] == 7'h00 &&
                         !err_ff[m]; // R4
         end
      end
   end

   // Master side: stalled masters see ready low
   always_comb begin
      for (int m = 0; m < NM; m++) begin
         m_rsp[m] = '0;
         if (err_ff[m]) begin
            m_rsp[m].ready = 1'b1;
            m_rsp[m].error = 1'b1; // R4
         end
         for (int s = 0; s < NS; s++) begin
            if (grant_ff[s][m] && sel[m][s]) begin
               m_rsp[m] = s_rsp[s]; // R12
            end
         end
      end
   end

   // Peripheral bus clock enables; system clock is below both ceilings
   assign lo_periph_clk_en = !rst &&
      (bus_matrix_pkg::SYS_MHZ <= bus_matrix_pkg::APB_LO_MAX_MHZ); // R10
   assign hi_periph_clk_en = !rst &&
      (bus_matrix_pkg::SYS_MHZ <= bus_matrix_pkg::APB_HI_MAX_MHZ); // R11

   // Checks watch only what the matrix itself drives
   generate
      for (genvar s = 0; s < NS; s++) begin : g_chk
         one_grant_a: assert property ( // R12
            @(posedge clock) disable iff (rst)
            $onehot0(grant_ff[s]))
            else $error("more than one master granted");
         hold_grant_a: assert property ( // R12
            @(posedge clock) disable iff (rst)
            (grant_ff[s] != '0 && (want[s] & grant_ff[s]) != '0 &&
             !s_rsp[s].ready) |=> grant_ff[s] == $past(grant_ff[s]))
            else $error("grant dropped mid transfer");
         // Back-to-back requests from one master must not lock others out
         hand_over_a: assert property ( // R12
            @(posedge clock) disable iff (rst)
            (s_rsp[s].ready && s_req[s].valid &&
             (want[s] & ~grant_ff[s]) != '0)
            |=> (grant_ff[s] & $past(grant_ff[s])) == '0)
            else $error("waiting master passed over");
         legal_path_a: assert property ( // R4
            @(posedge clock) disable iff (rst)
            s_req[s].valid |-> (grant_ff[s] & want[s]) != '0)
            else $error("slave request without grant");
         for (genvar m = 0; m < NM; m++) begin : g_route
            req_route_a: assert property ( // R1
               @(posedge clock) disable iff (rst)
               (grant_ff[s][m] && sel[m][s]) |-> s_req[s] == m_req[m])
               else $error("slave sees another master");
            rsp_route_a: assert property ( // R1
               @(posedge clock) disable iff (rst)
               (grant_ff[s][m] && sel[m][s]) |-> m_rsp[m] == s_rsp[s])
               else $error("master sees another slave");
            // A pending error answer may still be on its way out
            stall_a: assert property ( // R12
               @(posedge clock) disable iff (rst)
               (want[s][m] && !grant_ff[s][m] && !err_ff[m])
               |-> !m_rsp[m].ready)
               else $error("stalled master saw ready");
         end
      end
      for (genvar m = 0; m < NM; m++) begin : g_mchk
         no_bad_path_a: assert property ( // R3
            @(posedge clock) disable iff (rst)
            (sel[m] & ~conn[m]) == '0)
            else $error("forbidden path selected");
         one_target_a: assert property ( // R1
            @(posedge clock) disable iff (rst)
            $onehot0(sel[m]))
            else $error("request routed to two slaves");
         err_answer_a: assert property ( // R4
            @(posedge clock) disable iff (rst)
            (m_req[m].valid && sel[m] == 7'h00 && !err_ff[m])
            |=> m_rsp[m].error)
            else $error("missing error answer");
         err_pulse_a: assert property ( // R4
            @(posedge clock) disable iff (rst)
            err_ff[m] |=> !err_ff[m])
            else $error("error answer held too long");
         flash_data_a: assert property ( // R8
            @(posedge clock) disable iff (rst)
            (m_req[m].valid && conn[m][bus_matrix_pkg::S_FLASH_D] &&
             m_req[m].addr <= bus_matrix_pkg::CODE_HI)
            |-> sel[m][bus_matrix_pkg::S_FLASH_D])
            else $error("code access missed flash data port");
         apb_split_a: assert property ( // R9
            @(posedge clock) disable iff (rst)
            (m_req[m].valid && conn[m][bus_matrix_pkg::S_APB_HI] &&
             m_req[m].addr >= bus_matrix_pkg::APB_HI_LO &&
             m_req[m].addr <= bus_matrix_pkg::APB_HI_HI)
            |-> sel[m][bus_matrix_pkg::S_APB_HI])
            else $error("fast peripheral access misrouted");
      end
   endgenerate

   // Code region fetches must never land on the data side of flash
   instr_code_a: assert property ( // R5
      @(posedge clock) disable iff (rst)
      (m_req[bus_matrix_pkg::M_INSTR].valid &&
       m_req[bus_matrix_pkg::M_INSTR].addr <= bus_matrix_pkg::CODE_HI)
      |-> sel[bus_matrix_pkg::M_INSTR][bus_matrix_pkg::S_FLASH_I])
      else $error("instruction fetch missed its flash port");
   data_flash_a: assert property ( // R6
      @(posedge clock) disable iff (rst)
      !sel[bus_matrix_pkg::M_DATA][bus_matrix_pkg::S_FLASH_I])
      else $error("data master on flash instruction port");
   data_debug_a: assert property ( // R6
      @(posedge clock) disable iff (rst)
      (m_req[bus_matrix_pkg::M_DATA].valid &&
       m_req[bus_matrix_pkg::M_DATA].addr <= bus_matrix_pkg::CODE_HI)
      |-> sel[bus_matrix_pkg::M_DATA][bus_matrix_pkg::S_FLASH_D])
      else $error("data master missed code region");
   sys_no_flash_a: assert property ( // R7
      @(posedge clock) disable iff (rst)
      sel[bus_matrix_pkg::M_SYS][1:0] == 2'h0)
      else $error("system master reached flash");
   sys_sram_a: assert property ( // R7
      @(posedge clock) disable iff (rst)
      (m_req[bus_matrix_pkg::M_SYS].valid &&
       m_req[bus_matrix_pkg::M_SYS].addr >= bus_matrix_pkg::SRAM_LO &&
       m_req[bus_matrix_pkg::M_SYS].addr <= bus_matrix_pkg::SRAM_HI)
      |-> sel[bus_matrix_pkg::M_SYS][bus_matrix_pkg::S_SRAM])
      else $error("system master missed SRAM");
   // Ceilings are fixed at build time, so the enables drop only while rst is high
   lo_clk_a: assert property ( // R10
      @(posedge clock) disable iff (rst)
      lo_periph_clk_en)
      else $error("low speed bus clock stopped");
   hi_clk_a: assert property ( // R11
      @(posedge clock) disable iff (rst)
      hi_periph_clk_en)
      else $error("high speed bus clock stopped");
endmodule // multilayer_bus_matrix

// *** design/bus_matrix_pkg.sv ***
/*
 Package for the multilayer bus matrix: port counts, region map,
 connectivity table, and the packed request/response carriers.
 Assumes AHB-lite style masters and slaves on one system clock.
*/
package bus_matrix_pkg;
   localparam int NUM_MASTERS = 5;
   localparam int NUM_SLAVES = 7;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   // Master indices
   localparam int M_INSTR = 0;
   localparam int M_DATA = 1;
   localparam int M_SYS = 2;
   localparam int M_DMA_A = 3;
   localparam int M_DMA_B = 4;

   // Slave indices
   localparam int S_FLASH_I = 0;
   localparam int S_FLASH_D = 1;
   localparam int S_SRAM = 2;
   localparam int S_EXTMEM = 3;
   localparam int S_AHB = 4;
   localparam int S_APB_LO = 5;
   localparam int S_APB_HI = 6;

   // Connectivity: bit s of entry m set when master m may reach slave s
   localparam logic [6:0] CONN_INSTR = 7'h0D;
   localparam logic [6:0] CONN_DATA = 7'h0E;
   localparam logic [6:0] CONN_SYS = 7'h7C;
   localparam logic [6:0] CONN_DMA = 7'h7E;

   // Address regions
   localparam logic [31:0] CODE_LO = 32'h0000_0000;
   localparam logic [31:0] CODE_HI = 32'h1FFF_FFFF;
   localparam logic [31:0] SRAM_LO = 32'h2000_0000;
   localparam logic [31:0] SRAM_HI = 32'h3FFF_FFFF;
   localparam logic [31:0] APB_LO_LO = 32'h4000_0000;
   localparam logic [31:0] APB_LO_HI = 32'h4000_FFFF;
   localparam logic [31:0] APB_HI_LO = 32'h4001_0000;
   localparam logic [31:0] APB_HI_HI = 32'h4001_FFFF;
   localparam logic [31:0] AHB_LO = 32'h4002_0000;
   localparam logic [31:0] AHB_HI = 32'h5FFF_FFFF;
   localparam logic [31:0] EXT_LO = 32'h6000_0000;
   localparam logic [31:0] EXT_HI = 32'hA000_0FFF;

   // Bus clock ceilings and the system clock, in MHz
   localparam int APB_LO_MAX_MHZ = 54;
   localparam int APB_HI_MAX_MHZ = 108;
   localparam int SYS_MHZ = 50;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } req_s;

   typedef struct packed {
      logic ready;
      logic error;
      logic [31:0] rdata;
   } rsp_s;
endpackage

// *** bench/slave_model.sv ***
/*
 Behavioural bank of the seven slave ports behind the matrix.
 Assumes the matrix holds each slave request until ready is seen.
*/
`timescale 1ns/1ns
module slave_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] wait_cycles,
   input wire bus_matrix_pkg::req_s s_req [7],
   output bus_matrix_pkg::rsp_s s_rsp [7]
);
   logic [3:0] cnt_ff [7];
   logic [6:0] rdy_ff;

   always_ff @(posedge clock or posedge rst) begin
      for (int s = 0; s < 7; s++) begin
         if (rst) begin
            cnt_ff[s] <= 4'h0;
            rdy_ff[s] <= 1'b0;
         end else if (s_req[s].valid && !rdy_ff[s]) begin
            rdy_ff[s] <= (cnt_ff[s] >= wait_cycles);
            cnt_ff[s] <= cnt_ff[s] + 4'h1;
         end else begin
            rdy_ff[s] <= 1'b0;
            cnt_ff[s] <= 4'h0;
         end
      end
   end

   // Data tags the port index; inverted when not ready, never stale
   always_comb begin
      for (int s = 0; s < 7; s++) begin
         s_rsp[s].ready = rdy_ff[s];
         s_rsp[s].error = 1'b0;
         s_rsp[s].rdata = {4'(s), s_req[s].addr[27:0]};
         if (!rdy_ff[s]) s_rsp[s].rdata = ~s_rsp[s].rdata;
      end
   end
endmodule // slave_model

// *** bench/tb_top.sv ***
/*
 Self-checking bench for the bus matrix: path table, parallel paths,
 contention and bus clock enables. Assumes slave_model as far side.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
   logic clock;
   logic rst;
   logic [3:0] wait_cycles;
   bus_matrix_pkg::req_s m_req [5];
   bus_matrix_pkg::rsp_s m_rsp [5];
   bus_matrix_pkg::req_s s_req [7];
   bus_matrix_pkg::rsp_s s_rsp [7];
   logic lo_periph_clk_en;
   logic hi_periph_clk_en;
   int fail_count;
   int n_checks;
   time ta;
   time tb;

   multilayer_bus_matrix u_dut (.clock(clock), .rst(rst), .m_req(m_req),
      .m_rsp(m_rsp), .s_req(s_req), .s_rsp(s_rsp),
      .lo_periph_clk_en(lo_periph_clk_en),
      .hi_periph_clk_en(hi_periph_clk_en));
   slave_model u_slaves (.clock(clock), .rst(rst),
      .wait_cycles(wait_cycles), .s_req(s_req), .s_rsp(s_rsp));

   always #10 clock = ~clock;

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One write; es is the expected slave index, 7 for a refusal
   task automatic xfer(input int m, input logic [31:0] a, input int es,
                       output time t_done);
      logic [31:0] wd;
      wd = a ^ 32'h5A5A_5A5A;
      @(posedge clock);
      m_req[m] <= bus_matrix_pkg::req_s'{1'b1, 1'b1, a, wd};
      for (int i = 0; i < 40; i++) begin
         @(negedge clock);
         if (m_rsp[m].ready === 1'b1) break;
      end
      t_done = $time;
      `CHK(m_rsp[m].ready, 1'b1)
      `CHK(m_rsp[m].error, 1'(es == 7))
      if (es != 7) begin
         `CHK(m_rsp[m].rdata, {4'(es), a[27:0]})
         `CHK(s_req[es].wdata, wd)
         `CHK(s_req[es].addr, a)
      end
      @(posedge clock);
      m_req[m] <= '0;
   endtask

   task automatic path(input int m, input logic [31:0] a, input int es);
      time t;
      xfer(m, a, es, t);
   endtask

   task automatic path_table();
      path(0, 32'h0800_0000, 0);
      path(0, 32'h1FFF_FFFC, 0);
      path(0, 32'h4000_0000, 7);
      path(0, 32'h2000_0000, 2);
      path(0, 32'h6000_0000, 3);
      path(1, 32'h0800_0000, 1);
      path(1, 32'h2000_0000, 2);
      path(1, 32'h6000_0000, 3);
      path(1, 32'h4002_0000, 7);
      path(2, 32'h0800_0000, 7);
      path(2, 32'h2000_0100, 2);
      path(2, 32'h4002_1000, 4);
      path(2, 32'h4000_5000, 5);
      path(2, 32'h4001_0800, 6);
      path(2, 32'hA000_0000, 3);
      path(2, 32'hB000_0000, 7);
      path(3, 32'h0800_0000, 1);
      path(3, 32'h4000_0000, 5);
      path(4, 32'h4001_0000, 6);
      path(4, 32'h5000_0000, 4);
      path(4, 32'h6000_0000, 3);
   endtask

   task automatic parallel_paths();
      wait_cycles <= 4'h2;
      fork
         xfer(1, 32'h2000_0010, 2, ta);
         xfer(4, 32'h6000_0010, 3, tb);
      join
      `CHK(1'(ta == tb), 1'b1)
   endtask

   task automatic contention();
      wait_cycles <= 4'h3;
      fork
         xfer(2, 32'h2000_0020, 2, ta);
         xfer(3, 32'h2000_0040, 2, tb);
      join
      `CHK(1'(ta != tb), 1'b1)
      // Loser needs a whole slave cycle after the winner's ready
      `CHK(1'((ta > tb ? ta - tb : tb - ta) >= 100), 1'b1)
      wait_cycles <= 4'h0;
   endtask

   task automatic clock_enables();
      `CHK(lo_periph_clk_en, 1'b1)
      `CHK(hi_periph_clk_en, 1'b1)
   endtask

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      wait_cycles = 4'h0;
      fail_count = 0;
      n_checks = 0;
      foreach (m_req[i]) m_req[i] = '0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      clock_enables();
      path_table();
      parallel_paths();
      contention();
      path_table();
      summarize();
   end

   // Full run needs well under 1000 cycles
   initial begin
      #(20 * 5000);
      fail_count++;
      summarize();
   end
endmodule // tb_top
